// file: hw/baro_params.svh
// constants of the barometer control and interrupt routing block
// assumes a 40 MHz core clock; times are turned into cycle counts here
`ifndef BARO_PARAMS_SVH
`define BARO_PARAMS_SVH

`define BARO_MC_ADDR      7'h21
`define BARO_IPC_ADDR     7'h22
`define BARO_IPS_ADDR     7'h23

`define BARO_MC_RELOAD    7
`define BARO_MC_QEN       6
`define BARO_MC_WTM_EN    5
`define BARO_MC_DECIM     4
`define BARO_MC_TWD       3
`define BARO_MC_SOFT      2
`define BARO_MC_AZ        1
`define BARO_MC_SHOT      0

`define BARO_IPC_POL      7
`define BARO_IPC_DRIVE    6

`define BARO_MC_RST       8'h00
`define BARO_IPC_RST      8'h00
`define BARO_IPS_RST      8'h00
// packed pin configuration {pol, drive, sel, route} after reset
`define BARO_IRQ_CFG_RST  8'h00
`define BARO_RATE_SINGLE  3'h0

`define BARO_SEL_DATA     2'h0
`define BARO_SEL_HIGH     2'h1
`define BARO_SEL_LOW      2'h2
`define BARO_SEL_EITHER   2'h3

`define BARO_CLK_NS       25
`define BARO_RELOAD_NS    2200000
`define BARO_SOFT_NS      4000
`define BARO_DEC_NS       1000000000
`define BARO_RELOAD_CYC   ((`BARO_RELOAD_NS + `BARO_CLK_NS - 1) / `BARO_CLK_NS)
`define BARO_SOFT_CYC     ((`BARO_SOFT_NS + `BARO_CLK_NS - 1) / `BARO_CLK_NS)
`define BARO_DEC_CYC      ((`BARO_DEC_NS + `BARO_CLK_NS - 1) / `BARO_CLK_NS)

`endif

// file: hw/baro_pkg.sv
// types shared by the barometer control and interrupt routing block
// assumes nothing beyond the constants header
package baro_pkg;

  typedef enum logic {
    BARO_IDLE = 1'b0,
    BARO_RUN  = 1'b1
  } baro_phase_e;

  typedef struct packed {
    logic pol;
    logic drive;
    logic [1:0] sel;
    logic [3:0] route;
  } baro_irq_cfg_s;

  typedef struct packed {
    logic q_empty;
    logic q_wtm;
    logic q_ovr;
    logic new_sample_signal;
    logic p_high;
    logic p_low;
  } baro_irq_src_s;

endpackage

// file: hw/baro_tmr.sv
// one-shot interval timer: busy for CYC cycles after a start
// assumes start comes from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
module baro_tmr
  import baro_pkg::*;
#(
  parameter int unsigned CYC = 4 // length of the interval in cycles
)(
  input  wire logic clk_i,   // core clock
  input  wire logic reset_i, // synchronous reset, active high
  input  wire logic start_i, // start request, ignored while busy
  output logic      busy_o,  // interval running
  output logic      done_o   // last cycle of the interval
);
  localparam int unsigned CW = $clog2(CYC + 1);

  baro_phase_e     phase;
  logic [CW-1:0]   cnt;

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      phase <= BARO_IDLE;
      cnt   <= '0;
    end
    else
    begin
      case (phase)
        BARO_IDLE:
        begin
          if (start_i)
          begin
            phase <= BARO_RUN;
            cnt   <= CW'(CYC - 1);
          end
        end
        BARO_RUN:
        begin
          if (cnt == '0)
            phase <= BARO_IDLE;
          else
            cnt <= cnt - 1'b1;
        end
        default: phase <= BARO_IDLE;
      endcase
    end
  end

  assign busy_o = (phase == BARO_RUN);
  assign done_o = (phase == BARO_RUN) && (cnt == '0);
endmodule
`default_nettype wire

// file: hw/baro_irq_pin.sv
// interrupt pin driver: source select, polarity and drive type
// assumes configuration and sources are on the core clock
`timescale 1ns/1ps
`include "baro_params.svh"
`default_nettype none
module baro_irq_pin
  import baro_pkg::*;
(
  input  wire logic          clk_i,   // core clock
  input  wire logic          reset_i, // synchronous reset, active high
  input  wire baro_irq_cfg_s cfg_i,   // pin configuration
  input  wire baro_irq_src_s src_i,   // event sources
  output logic               pin_o,   // pin output level
  output logic               pin_oe_o // pin driven
);
  logic data_any;
  logic active;
  logic level;

  always_comb
  begin
    data_any = |(cfg_i.route & {src_i.q_empty, src_i.q_wtm, src_i.q_ovr,
                                src_i.new_sample_signal});
    case (cfg_i.sel)
      `BARO_SEL_DATA:   active = data_any;
      `BARO_SEL_HIGH:   active = src_i.p_high;
      `BARO_SEL_LOW:    active = src_i.p_low;
      `BARO_SEL_EITHER: active = src_i.p_high | src_i.p_low;
      default:          active = 1'b0;
    endcase
    level = active ^ cfg_i.pol;
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      pin_o    <= 1'b0;
      pin_oe_o <= 1'b1;
    end
    else if (cfg_i.drive)
    begin
      pin_o    <= 1'b0;
      pin_oe_o <= ~level;
    end
    else
    begin
      pin_o    <= level;
      pin_oe_o <= 1'b1;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  property p_od_low;
    cfg_i.drive |=> !pin_o;
  endproperty
  a_od_low: assert property (p_od_low) else $error("open drain pin driven high");

  property p_high_pol;
    !cfg_i.drive && cfg_i.sel == `BARO_SEL_HIGH |=> pin_oe_o && pin_o == ($past(src_i.p_high) ^ $past(cfg_i.pol));
  endproperty
  a_high_pol: assert property (p_high_pol) else $error("pressure high level or polarity wrong");

  property p_data_or;
    !cfg_i.drive && !cfg_i.pol && cfg_i.sel == `BARO_SEL_DATA && cfg_i.route[0] && src_i.new_sample_signal |=> pin_o;
  endproperty
  a_data_or: assert property (p_data_or) else $error("new sample not shown on pin");
endmodule
`default_nettype wire

// file: hw/baro_ctrl.sv
// measurement control and interrupt pin registers of the barometer
// assumes the serial interface drives the register port on ref_clk_i
`timescale 1ns/1ps
`include "baro_params.svh"
`default_nettype none
// Operation
// - writing reload bit 7 starts a calibration reload, bit clears when done
// - reload copies factory trim values into trim registers, also after power-up
// - bit 6 enables the sample queue, reset value 0
// - bit 5 enables the queue watermark flag, reset value 0
// - bit 4 decimates moving average output to 1 Hz in mean mode
// - bit 3 set disables the two-wire port, reset value 0
// - soft restart bit restores power-on configuration in 4 us then clears
// - autozero bit captures current pressure as reference and subtracts it
// - single-conversion bit in rate 000 triggers one pressure and temperature measurement
// - finished single conversion clears the bit; results and status updated
// - interrupt control bit 7 selects pin polarity, 0 active high
// - interrupt control bit 6 selects push-pull or open drain
// - source field selects data, pressure high, pressure low, or either
// - routed new sample signal marks a new pressure sample
// - route bit 3 puts queue empty on the pin
// - route bit 2 puts queue watermark on the pin
// - route bit 1 puts queue overrun on the pin
// - route bit 0 puts new sample signal on the pin, reset 0
// - rate field 000 means conversions only on host request
// - reference is 24-bit two's complement subtracted for thresholds and autozero
module baro_ctrl
  import baro_pkg::*;
#(
  parameter int unsigned RELOAD_CYC = `BARO_RELOAD_CYC, // reload length in cycles
  parameter int unsigned DEC_CYC    = `BARO_DEC_CYC,    // decimation period in cycles
  parameter int unsigned TRIM_W     = 8                 // trim word width
)(
  input  wire logic              ref_clk_i,                // core clock, 40 MHz
  input  wire logic              reset_i,                  // power-on reset, sync, high
  input  wire logic [6:0]        reg_addr_i,               // register address
  input  wire logic              reg_wr_i,                 // write strobe
  input  wire logic              reg_rd_i,                 // read strobe
  input  wire logic [7:0]        reg_wdata_i,              // write data
  output logic      [7:0]        reg_rdata_o,              // read data, next cycle
  input  wire logic [2:0]        rate_select_i,            // output rate field
  input  wire logic              conv_done_i,              // conversion finished pulse
  input  wire logic [23:0]       press_i,                  // measured pressure
  input  wire logic              mean_mode_i,              // queue in moving average mode
  input  wire logic              avg_valid_i,              // new moving average pulse
  input  wire logic [TRIM_W-1:0] nvm_trim_i,               // factory trim from storage
  input  wire baro_irq_src_s     irq_src_i,                // interrupt event sources
  output logic                   conv_start_o,             // start one conversion pulse
  output logic                   single_mode_o,            // host-requested conversions
  output logic                   trim_fetch_o,             // trim storage being read
  output logic                   reload_busy_o,            // reload in progress
  output logic      [TRIM_W-1:0] trim_o,                   // internal trim registers
  output logic      [23:0]       ref_o,                    // reference pressure
  output logic      [23:0]       press_out_o,              // pressure output value
  output logic      [23:0]       press_diff_o,             // pressure minus reference
  output logic                   avg_update_o,             // averaged output update pulse
  output logic                   queue_enable_o,           // sample queue enable
  output logic                   watermark_flag_enable_o,  // watermark flag enable
  output logic                   queue_watermark_flag_o,   // gated watermark status
  output logic                   two_wire_port_disable_o,  // two-wire port off
  output logic                   irq_ready_pin_o,          // interrupt pin level
  output logic                   irq_ready_pin_oe_o        // interrupt pin driven
);
  localparam int unsigned DW = $clog2(DEC_CYC + 1);

  logic [7:0]    mc;
  baro_irq_cfg_s irq_cfg;
  logic [23:0]   ref_p;
  logic [23:0]   press_rel;
  logic          boot_pend;
  logic          rl_busy;
  logic          rl_done;
  logic          sr_busy;
  logic          sr_done;
  logic          wr_mc;
  logic          wr_ipc;
  logic          wr_ips;
  logic          single;
  logic          shot_req;
  logic          rl_start;
  logic [DW-1:0] dec_cnt;

  function automatic logic hit(input logic [6:0] a, input logic [6:0] off);
    hit = (a == off);
  endfunction

  function automatic logic [7:0] rd_mux(input logic [6:0] a, input logic [7:0] m,
                                        input baro_irq_cfg_s c);
    if (hit(a, `BARO_MC_ADDR))
      rd_mux = m;
    else if (hit(a, `BARO_IPC_ADDR))
      rd_mux = {c.pol, c.drive, 4'h0, c.sel};
    else if (hit(a, `BARO_IPS_ADDR))
      rd_mux = {4'h0, c.route};
    else
      rd_mux = 8'h00;
  endfunction

  assign wr_mc     = reg_wr_i && hit(reg_addr_i, `BARO_MC_ADDR) && !sr_busy;
  assign wr_ipc    = reg_wr_i && hit(reg_addr_i, `BARO_IPC_ADDR) && !sr_busy;
  assign wr_ips    = reg_wr_i && hit(reg_addr_i, `BARO_IPS_ADDR) && !sr_busy;
  assign single    = (rate_select_i == `BARO_RATE_SINGLE);
  assign shot_req  = wr_mc && reg_wdata_i[`BARO_MC_SHOT] && single && !mc[`BARO_MC_SHOT];
  assign rl_start  = boot_pend || (wr_mc && reg_wdata_i[`BARO_MC_RELOAD] && !rl_busy);
  assign press_rel = press_i - ref_p;

  baro_tmr #(
    .CYC     (RELOAD_CYC)
  ) u_reload_tmr (
    .clk_i   (ref_clk_i),
    .reset_i (reset_i),
    .start_i (rl_start),
    .busy_o  (rl_busy),
    .done_o  (rl_done)
  );

  baro_tmr #(
    .CYC     (`BARO_SOFT_CYC)
  ) u_soft_tmr (
    .clk_i   (ref_clk_i),
    .reset_i (reset_i),
    .start_i (wr_mc && reg_wdata_i[`BARO_MC_SOFT]),
    .busy_o  (sr_busy),
    .done_o  (sr_done)
  );

  baro_irq_pin u_irq_pin (
    .clk_i    (ref_clk_i),
    .reset_i  (reset_i),
    .cfg_i    (irq_cfg),
    .src_i    (irq_src_i),
    .pin_o    (irq_ready_pin_o),
    .pin_oe_o (irq_ready_pin_oe_o)
  );

  // power-up reload request, one cycle after reset release
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
      boot_pend <= 1'b1;
    else
      boot_pend <= 1'b0;
  end

  // measurement control register
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i || sr_done)
      mc <= `BARO_MC_RST;
    else
    begin
      if (rl_done)
        mc[`BARO_MC_RELOAD] <= 1'b0;
      if (conv_done_i)
        mc[`BARO_MC_SHOT] <= 1'b0;
      if (wr_mc)
      begin
        if (reg_wdata_i[`BARO_MC_RELOAD] && !rl_busy)
          mc[`BARO_MC_RELOAD] <= 1'b1;
        mc[`BARO_MC_QEN]    <= reg_wdata_i[`BARO_MC_QEN];
        mc[`BARO_MC_WTM_EN] <= reg_wdata_i[`BARO_MC_WTM_EN];
        mc[`BARO_MC_DECIM]  <= reg_wdata_i[`BARO_MC_DECIM];
        mc[`BARO_MC_TWD]    <= reg_wdata_i[`BARO_MC_TWD];
        mc[`BARO_MC_SOFT]   <= reg_wdata_i[`BARO_MC_SOFT];
        mc[`BARO_MC_AZ]     <= reg_wdata_i[`BARO_MC_AZ];
        if (shot_req)
          mc[`BARO_MC_SHOT] <= 1'b1;
      end
    end
  end

  // interrupt pin control and source routing
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i || sr_done)
      irq_cfg <= baro_irq_cfg_s'(`BARO_IRQ_CFG_RST);
    else
    begin
      if (wr_ipc)
      begin
        irq_cfg.pol   <= reg_wdata_i[`BARO_IPC_POL];
        irq_cfg.drive <= reg_wdata_i[`BARO_IPC_DRIVE];
        irq_cfg.sel   <= reg_wdata_i[1:0];
      end
      if (wr_ips)
        irq_cfg.route <= reg_wdata_i[3:0];
    end
  end

  // factory trim copy at the end of every reload
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      trim_o       <= '0;
      trim_fetch_o <= 1'b0;
    end
    else
    begin
      trim_fetch_o <= rl_start || (rl_busy && !rl_done);
      if (rl_done)
        trim_o <= nvm_trim_i;
    end
  end

  // autozero reference capture and subtraction
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i || sr_done)
      ref_p <= 24'h000000;
    else if (wr_mc && reg_wdata_i[`BARO_MC_AZ])
      ref_p <= press_i;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      press_out_o  <= 24'h000000;
      press_diff_o <= 24'h000000;
    end
    else
    begin
      press_diff_o <= press_rel;
      press_out_o  <= mc[`BARO_MC_AZ] ? press_rel : press_i;
    end
  end

  // single conversion request
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      conv_start_o  <= 1'b0;
      single_mode_o <= 1'b0;
    end
    else
    begin
      conv_start_o  <= shot_req;
      single_mode_o <= single;
    end
  end

  // one averaged update per decimation period when enabled in mean mode
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i || sr_done)
    begin
      dec_cnt      <= '0;
      avg_update_o <= 1'b0;
    end
    else if (mc[`BARO_MC_DECIM] && mean_mode_i)
    begin
      avg_update_o <= avg_valid_i && (dec_cnt == '0);
      if (avg_valid_i && dec_cnt == '0)
        dec_cnt <= DW'(DEC_CYC - 1);
      else if (dec_cnt != '0)
        dec_cnt <= dec_cnt - 1'b1;
    end
    else
    begin
      avg_update_o <= avg_valid_i;
      dec_cnt      <= '0;
    end
  end

  // status mirrors and read data
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      reg_rdata_o            <= 8'h00;
      reload_busy_o          <= 1'b0;
      queue_watermark_flag_o <= 1'b0;
    end
    else
    begin
      reload_busy_o          <= rl_start || (rl_busy && !rl_done);
      queue_watermark_flag_o <= mc[`BARO_MC_WTM_EN] && irq_src_i.q_wtm;
      if (reg_rd_i)
        reg_rdata_o <= rd_mux(reg_addr_i, mc, irq_cfg);
    end
  end

  assign queue_enable_o          = mc[`BARO_MC_QEN];
  assign watermark_flag_enable_o = mc[`BARO_MC_WTM_EN];
  assign two_wire_port_disable_o = mc[`BARO_MC_TWD];

  // checks
  localparam int SR_LIM = `BARO_SOFT_CYC + 3;
  logic [31:0] rl_len;

  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i || !rl_busy)
      rl_len <= 32'h00000000;
    else
      rl_len <= rl_len + 32'h00000001;
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);

  sequence s_shot_req;
    wr_mc && reg_wdata_i[`BARO_MC_SHOT] && single && !mc[`BARO_MC_SHOT];
  endsequence

  sequence s_shot_taken;
    conv_start_o && mc[`BARO_MC_SHOT] ##1 !conv_start_o;
  endsequence

  property p_reload_len;
    $fell(rl_busy) |-> rl_len == RELOAD_CYC && !mc[`BARO_MC_RELOAD];
  endproperty
  a_reload_len: assert property (p_reload_len) else $error("reload length or bit clear wrong");

  property p_trim_copy;
    rl_done |=> trim_o == $past(nvm_trim_i);
  endproperty
  a_trim_copy: assert property (p_trim_copy) else $error("trim not copied at reload end");

  property p_soft_len;
    $rose(mc[`BARO_MC_SOFT]) |-> ##[1:SR_LIM] mc == `BARO_MC_RST && ref_p == 24'h000000;
  endproperty
  a_soft_len: assert property (p_soft_len) else $error("soft restart did not finish in time");

  property p_soft_cfg;
    sr_done |=> irq_cfg == '0 && !mc[`BARO_MC_SOFT];
  endproperty
  a_soft_cfg: assert property (p_soft_cfg) else $error("soft restart left configuration");

  property p_shot;
    s_shot_req |=> s_shot_taken;
  endproperty
  a_shot: assert property (p_shot) else $error("single conversion not started once");

  property p_shot_clear;
    mc[`BARO_MC_SHOT] && conv_done_i && !sr_done |=> !mc[`BARO_MC_SHOT];
  endproperty
  a_shot_clear: assert property (p_shot_clear) else $error("single bit not cleared");

  property p_az;
    wr_mc && reg_wdata_i[`BARO_MC_AZ] |=> ref_o == $past(press_i) && mc[`BARO_MC_AZ];
  endproperty
  a_az: assert property (p_az) else $error("autozero reference not captured");

  property p_az_out;
    mc[`BARO_MC_AZ] |=> press_out_o == $past(press_i) - $past(ref_o);
  endproperty
  a_az_out: assert property (p_az_out) else $error("autozero output not relative");

  property p_route_zero;
    reg_rd_i && hit(reg_addr_i, `BARO_IPS_ADDR) |=> reg_rdata_o[7:4] == 4'h0;
  endproperty
  a_route_zero: assert property (p_route_zero) else $error("route register upper bits not zero");

  property p_decim;
    avg_update_o && $past(mc[`BARO_MC_DECIM]) && $past(mean_mode_i) |-> dec_cnt == DW'(DEC_CYC - 1);
  endproperty
  a_decim: assert property (p_decim) else $error("decimated update too early");

  assign ref_o = ref_p;
endmodule
`default_nettype wire

// file: testbench/baro_host.sv
// host side of the register port: byte reads and writes on the core clock
// assumes the device answers a read on the edge after the read strobe
`timescale 1ns/1ps
`default_nettype none
module baro_host
(
  input  wire logic       clk_i,   // core clock
  input  wire logic [7:0] rdata_i, // read data from the device
  output logic      [6:0] addr_o,  // register address
  output logic            wr_o,    // write strobe
  output logic            rd_o,    // read strobe
  output logic      [7:0] wdata_o  // write data
);
  initial
  begin
    addr_o = 7'h00;
    wdata_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end

  // released lines show the inverse so stale values never look valid
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge clk_i);
    addr_o = a;
    wdata_o = d;
    wr_o = 1'b1;
    @(negedge clk_i);
    wr_o = 1'b0;
    addr_o = ~a;
    wdata_o = ~d;
  endtask

  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(negedge clk_i);
    addr_o = a;
    rd_o = 1'b1;
    @(negedge clk_i);
    rd_o = 1'b0;
    addr_o = ~a;
    d = rdata_i;
  endtask
endmodule
`default_nettype wire

// file: testbench/barometer_control_and_irq_routing_tb.sv
// self-checking bench of the measurement control and interrupt pin block
// assumes short reload and decimation counts set at the instance
`timescale 1ns/1ps
`default_nettype none
module barometer_control_and_irq_routing_tb
  import baro_pkg::*;
;
  logic          clk, rst, wr, rd, done, mean, avv;
  logic [6:0]    addr;
  logic [7:0]    wdata, rdata, nvm, trim;
  logic [2:0]    rate;
  logic [23:0]   press, ref_v, pout, pdiff;
  baro_irq_src_s src;
  logic          conv, single, fetch, busy, avu, qen, wen, wflag, twd, pin, pin_oe;
  int            bad_count = 0;
  int            checks_done = 0;
  int            cycles = 0;
  logic [21:0]   tbl [12] = '{{8'h00, 8'h01, 6'h04}, {8'h00, 8'h02, 6'h08}, {8'h00, 8'h04, 6'h10},
                              {8'h00, 8'h08, 6'h20}, {8'h00, 8'h07, 6'h23}, {8'h01, 8'h0F, 6'h02},
                              {8'h02, 8'h0F, 6'h02}, {8'h03, 8'h00, 6'h01}, {8'h80, 8'h01, 6'h04},
                              {8'h40, 8'h01, 6'h00}, {8'h40, 8'h01, 6'h04}, {8'hC0, 8'h0F, 6'h00}};

  baro_host host (.clk_i(clk), .rdata_i(rdata), .addr_o(addr), .wr_o(wr), .rd_o(rd), .wdata_o(wdata));

  baro_ctrl #(.RELOAD_CYC(20), .DEC_CYC(16), .TRIM_W(8)) uut (
    .ref_clk_i(clk), .reset_i(rst), .reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_wdata_i(wdata), .reg_rdata_o(rdata), .rate_select_i(rate), .conv_done_i(done),
    .press_i(press), .mean_mode_i(mean), .avg_valid_i(avv), .nvm_trim_i(nvm), .irq_src_i(src),
    .conv_start_o(conv), .single_mode_o(single), .trim_fetch_o(fetch), .reload_busy_o(busy),
    .trim_o(trim), .ref_o(ref_v), .press_out_o(pout), .press_diff_o(pdiff), .avg_update_o(avu),
    .queue_enable_o(qen), .watermark_flag_enable_o(wen), .queue_watermark_flag_o(wflag),
    .two_wire_port_disable_o(twd), .irq_ready_pin_o(pin), .irq_ready_pin_oe_o(pin_oe));

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic check(input string n, input logic [23:0] e, input logic [23:0] g);
    checks_done++;
    if (g !== e)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic rchk(input logic [6:0] a, input logic [7:0] e);
    logic [7:0] d;
    host.rd(a, d);
    check($sformatf("reg %h", a), e, d);
  endtask

  // expected {level, enable} of the interrupt pin
  function automatic logic [1:0] pin_exp(input logic [21:0] t);
    logic a;
    logic l;
    a = (t[15:14] == 2'h0) ? |(t[9:6] & t[5:2]) : (t[15:14] == 2'h1) ? t[1] :
        (t[15:14] == 2'h2) ? t[0] : (t[1] | t[0]);
    l = a ^ t[21];
    return t[20] ? {1'b0, ~l} : {l, 1'b1};
  endfunction

  task automatic pulse(input logic e, input string n);
    @(negedge clk);
    avv = 1'b1;
    @(negedge clk);
    avv = 1'b0;
    check(n, e, avu);
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      bad_count++;
      $display("[FAIL] timeout expected finish seen hang");
      test_done();
    end
  end

  initial
  begin
    rst = 1'b1;
    rate = 3'h1;
    done = 1'b0;
    mean = 1'b0;
    avv = 1'b0;
    press = 24'h000000;
    nvm = 8'h3C;
    src = '0;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    check("pin idle", 2'b01, {pin, pin_oe});
    rchk(7'h21, 8'h00);
    rchk(7'h22, 8'h00);
    rchk(7'h23, 8'h00);
    rchk(7'h20, 8'h00);
    check("boot busy", 2'b11, {busy, fetch});
    repeat (25) @(negedge clk);
    check("boot trim", 8'h3C, trim);
    $display("test reset done");
    nvm = 8'hA5;
    host.wr(7'h21, 8'h80);
    rchk(7'h21, 8'h80);
    check("reload busy", 1'b1, busy);
    repeat (25) @(negedge clk);
    rchk(7'h21, 8'h00);
    check("reload trim", 8'hA5, trim);
    $display("test reload done");
    host.wr(7'h21, 8'h68);
    src.q_wtm = 1'b1;
    repeat (2) @(negedge clk);
    check("ctrl on", 4'hF, {qen, wen, twd, wflag});
    host.wr(7'h21, 8'h08);
    repeat (2) @(negedge clk);
    check("ctrl off", 4'h2, {qen, wen, twd, wflag});
    rchk(7'h21, 8'h08);
    src = '0;
    $display("test control done");
    host.wr(7'h21, 8'h01);
    check("no start", 1'b0, conv);
    rchk(7'h21, 8'h00);
    rate = 3'h0;
    repeat (2) @(negedge clk);
    check("single mode", 1'b1, single);
    host.wr(7'h21, 8'h01);
    check("start", 1'b1, conv);
    @(negedge clk);
    check("start once", 1'b0, conv);
    rchk(7'h21, 8'h01);
    done = 1'b1;
    @(negedge clk);
    done = 1'b0;
    rchk(7'h21, 8'h00);
    $display("test single done");
    press = 24'h000100;
    host.wr(7'h21, 8'h02);
    check("ref", 24'h000100, ref_v);
    press = 24'h000150;
    repeat (2) @(negedge clk);
    check("out", 24'h000050, pout);
    press = 24'h0000F0;
    repeat (2) @(negedge clk);
    check("diff", 24'hFFFFF0, pdiff);
    $display("test autozero done");
    mean = 1'b1;
    host.wr(7'h21, 8'h00);
    pulse(1'b1, "avg plain");
    host.wr(7'h21, 8'h10);
    repeat (20) @(negedge clk);
    pulse(1'b1, "avg first");
    @(negedge clk);
    pulse(1'b0, "avg held");
    repeat (10) @(negedge clk);
    pulse(1'b0, "avg one early");
    pulse(1'b1, "avg period");
    $display("test decimate done");
    host.wr(7'h22, 8'hFF);
    rchk(7'h22, 8'hC3);
    host.wr(7'h23, 8'hFF);
    rchk(7'h23, 8'h0F);
    for (int i = 0; i < 12; i++)
    begin
      host.wr(7'h22, tbl[i][21:14]);
      host.wr(7'h23, tbl[i][13:6]);
      src = tbl[i][5:0];
      repeat (2) @(negedge clk);
      check($sformatf("pin case %0d", i), pin_exp(tbl[i]), {pin, pin_oe});
    end
    src = '0;
    $display("test irq done");
    host.wr(7'h21, 8'h04);
    rchk(7'h21, 8'h04);
    host.wr(7'h23, 8'h05);
    rchk(7'h23, 8'h0F);
    repeat (170) @(negedge clk);
    rchk(7'h21, 8'h00);
    rchk(7'h22, 8'h00);
    rchk(7'h23, 8'h00);
    check("ref cleared", 24'h000000, ref_v);
    host.wr(7'h21, 8'h80);
    @(negedge clk);
    check("reload after restart", 1'b1, busy);
    $display("test restart done");
    test_done();
  end
endmodule
`default_nettype wire
